// [inc/rtb_cfg.svh]
// Addresses, field positions and reset values of the receive/transmit control bank
`ifndef RTB_CFG_SVH
`define RTB_CFG_SVH

// Command and write addresses
`define RTB_ADDR_RESET   8'h1a
`define RTB_ADDR_GEN_WR  8'h1b
`define RTB_ADDR_RXC_WR  8'h1c
`define RTB_ADDR_RXM_WR  8'h1d
`define RTB_ADDR_TXC_WR  8'h1e
`define RTB_ADDR_OFS_WR  8'h1f

// Read-back addresses
`define RTB_ADDR_GEN_RD  8'heb
`define RTB_ADDR_RXC_RD  8'hec
`define RTB_ADDR_RXM_RD  8'hed
`define RTB_ADDR_TXC_RD  8'hee
`define RTB_ADDR_OFS_RD  8'hef

// Reset value of every register
`define RTB_REG_RESET    8'h00

// Field positions
`define RTB_GEN_AMP_BIT  5
`define RTB_GEN_PWR_HI   5
`define RTB_RXC_DRV_BIT  7
`define RTB_RXC_COR_BIT  6
`define RTB_RXC_RF_HI    4
`define RTB_RXC_RF_LO    2
`define RTB_RXC_BB_HI    1
`define RTB_RXC_BB_LO    0
`define RTB_RXM_SEL_HI   7
`define RTB_RXM_SEL_LO   6
`define RTB_RXM_IINV_BIT 5
`define RTB_RXM_QINV_BIT 4
`define RTB_RXM_LO_HI    3
`define RTB_RXM_LO_LO    0
`define RTB_TXC_SRC_BIT  7
`define RTB_TXC_TRIM_HI  3
`define RTB_TXC_TRIM_LO  0
`define RTB_OFS_I_HI     3
`define RTB_OFS_I_LO     0
`define RTB_OFS_Q_HI     7
`define RTB_OFS_Q_LO     4

// Serial framing: last bit index of a byte
`define RTB_BIT_LAST     3'h7

`endif

// [inc/rtb_pkg.sv]
// Types shared by the receive/transmit control bank
package rtb_pkg;

	// Serial port phase, one-hot
	typedef enum logic [4:0] {
		RTB_ST_IDLE = 5'h01,
		RTB_ST_ADDR = 5'h02,
		RTB_ST_DATA = 5'h04,
		RTB_ST_READ = 5'h08,
		RTB_ST_HOLD = 5'h10
	} rtb_phase_t;

	typedef logic [7:0] rtb_byte_t;

endpackage : rtb_pkg

// [verilog/rtb_ofs_dec.sv]
// Sign and magnitude decode of one DC offset correction field
`timescale 1ns/10ps
module rtb_ofs_dec (
	input  wire logic [3:0] i_code,
	output logic            o_neg,
	output logic      [2:0] o_mag
);

	// Both zero-magnitude codes mean no correction, so no sign either
	assign o_mag = i_code[2:0];
	assign o_neg = i_code[3] & (|i_code[2:0]);

endmodule : rtb_ofs_dec

// [verilog/rtb_serial_port.sv]
// Serial command port: address byte, then one data byte in or out
`timescale 1ns/10ps
`include "rtb_cfg.svh"
module rtb_serial_port (
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic              i_sel_n,
	input  wire logic              i_sclk,
	input  wire logic              i_cdata,
	input  wire logic              i_rd_load,
	input  wire rtb_pkg::rtb_byte_t i_rd_word,
	output rtb_pkg::rtb_byte_t     o_addr,
	output logic                   o_addr_stb,
	output rtb_pkg::rtb_byte_t     o_data,
	output logic                   o_data_stb,
	output logic                   o_rdata,
	output logic                   o_rdata_oe
);

	rtb_pkg::rtb_phase_t state_q;
	rtb_pkg::rtb_byte_t  sh_q;
	rtb_pkg::rtb_byte_t  rd_q;
	logic          [2:0] cnt_q;
	logic                sclk_q;
	wire                 rise = i_sclk & ~sclk_q;
	wire                 last = (cnt_q == `RTB_BIT_LAST);
	wire           [7:0] sh_nx = {sh_q[6:0], i_cdata};

	always_ff @(posedge i_clk)
	begin
		sclk_q     <= i_sclk;
		o_addr_stb <= 1'b0;
		o_data_stb <= 1'b0;
		if (i_rst || i_sel_n)
		begin
			state_q    <= rtb_pkg::RTB_ST_IDLE;
			cnt_q      <= 3'h0;
			rd_q       <= `RTB_REG_RESET;
			o_rdata_oe <= 1'b0;
			if (i_rst)
			begin
				sh_q   <= `RTB_REG_RESET;
				o_addr <= `RTB_REG_RESET;
				o_data <= `RTB_REG_RESET;
			end
		end
		else
		begin
			unique case (state_q)
				rtb_pkg::RTB_ST_IDLE: state_q <= rtb_pkg::RTB_ST_ADDR;
				rtb_pkg::RTB_ST_ADDR, rtb_pkg::RTB_ST_DATA:
				begin
					if (i_rd_load)
					begin
						state_q    <= rtb_pkg::RTB_ST_READ;
						rd_q       <= i_rd_word;
						o_rdata_oe <= 1'b1;
					end
					else if (rise)
					begin
						sh_q  <= sh_nx;
						cnt_q <= cnt_q + 3'h1;
						if (last && state_q == rtb_pkg::RTB_ST_ADDR)
						begin
							o_addr     <= sh_nx;
							o_addr_stb <= 1'b1;
							state_q    <= rtb_pkg::RTB_ST_DATA;
						end
						else if (last)
						begin
							o_data     <= sh_nx;
							o_data_stb <= 1'b1;
							state_q    <= rtb_pkg::RTB_ST_HOLD;
						end
					end
				end
				// Host samples on the rise, so the next bit follows it
				rtb_pkg::RTB_ST_READ:
				begin
					if (rise)
					begin
						rd_q  <= {rd_q[6:0], 1'b0};
						cnt_q <= cnt_q + 3'h1;
						if (last)
						begin
							state_q    <= rtb_pkg::RTB_ST_HOLD;
							o_rdata_oe <= 1'b0;
						end
					end
				end
				// Extra bytes in one frame are ignored
				rtb_pkg::RTB_ST_HOLD: state_q <= rtb_pkg::RTB_ST_HOLD;
				default: state_q <= rtb_pkg::RTB_ST_IDLE;
			endcase
		end
	end

	assign o_rdata = rd_q[7];

endmodule : rtb_serial_port

// [verilog/rtb_top.sv]
// Receive/transmit control register bank behind a serial command port
`timescale 1ns/10ps
`include "rtb_cfg.svh"
module rtb_top (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_sel_n,
	input  wire logic       i_sclk,
	input  wire logic       i_cdata,
	output logic            o_rdata,
	output logic            o_rdata_oe,
	output logic            o_powersave,
	output logic      [7:0] o_gen_ctrl,
	output logic            o_rx_output_drive_boost,
	output logic            o_iq_balance_fix_enable,
	output logic      [2:0] o_rf_gain_step,
	output logic      [1:0] o_bb_gain_step,
	output logic            o_rx_i_enable,
	output logic            o_rx_q_enable,
	output logic            o_i_amp_on,
	output logic            o_q_amp_on,
	output logic      [3:0] o_lo_level_trim,
	output logic            o_tx_lo_source_sel,
	output logic      [3:0] o_tx_lo_path_trim,
	output logic            o_i_offset_neg,
	output logic      [2:0] o_i_offset_mag,
	output logic            o_q_offset_neg,
	output logic      [2:0] o_q_offset_mag
);

	// ==========================================================
	// Serial port
	// ==========================================================
	rtb_pkg::rtb_byte_t addr;
	rtb_pkg::rtb_byte_t data;
	rtb_pkg::rtb_byte_t rd_word;
	logic               addr_stb;
	logic               data_stb;
	logic               rd_load;

	rtb_serial_port u_port (
		.i_clk      (i_clk),
		.i_rst      (i_rst),
		.i_sel_n    (i_sel_n),
		.i_sclk     (i_sclk),
		.i_cdata    (i_cdata),
		.i_rd_load  (rd_load),
		.i_rd_word  (rd_word),
		.o_addr     (addr),
		.o_addr_stb (addr_stb),
		.o_data     (data),
		.o_data_stb (data_stb),
		.o_rdata    (o_rdata),
		.o_rdata_oe (o_rdata_oe)
	);

	// ==========================================================
	// Register storage
	// ==========================================================
	rtb_pkg::rtb_byte_t gen_q;
	rtb_pkg::rtb_byte_t rxc_q;
	rtb_pkg::rtb_byte_t rxm_q;
	rtb_pkg::rtb_byte_t txc_q;
	rtb_pkg::rtb_byte_t ofs_q;

	// ==========================================================
	// Address decode
	// ==========================================================
	// reset command detect
	wire clr_cmd = addr_stb && (addr == `RTB_ADDR_RESET);
	wire clr_all = i_rst || clr_cmd;

	wire wr_gen = data_stb && (addr == `RTB_ADDR_GEN_WR);
	wire wr_rxc = data_stb && (addr == `RTB_ADDR_RXC_WR);
	wire wr_rxm = data_stb && (addr == `RTB_ADDR_RXM_WR);
	wire wr_txc = data_stb && (addr == `RTB_ADDR_TXC_WR);
	wire wr_ofs = data_stb && (addr == `RTB_ADDR_OFS_WR);

	wire rd_gen = (addr == `RTB_ADDR_GEN_RD);
	wire rd_rxc = (addr == `RTB_ADDR_RXC_RD);
	wire rd_rxm = (addr == `RTB_ADDR_RXM_RD);
	wire rd_txc = (addr == `RTB_ADDR_TXC_RD);
	wire rd_ofs = (addr == `RTB_ADDR_OFS_RD);
	wire rd_hit = rd_gen | rd_rxc | rd_rxm | rd_txc | rd_ofs;

	// A write address never starts a read, so its data phase stays inbound
	assign rd_load = addr_stb & rd_hit;

	assign rd_word = rd_gen ? gen_q :
	                 rd_rxc ? rxc_q :
	                 rd_rxm ? rxm_q :
	                 rd_txc ? txc_q :
	                 rd_ofs ? ofs_q : `RTB_REG_RESET;

	// ==========================================================
	// Register writes
	// ==========================================================
	// reserved bits kept; are the host's duty
	always_ff @(posedge i_clk)
	begin
		if (clr_all)
			gen_q <= `RTB_REG_RESET;
		else if (wr_gen)
			gen_q <= data;
	end

	always_ff @(posedge i_clk)
	begin
		if (clr_all)
			rxc_q <= `RTB_REG_RESET;
		else if (wr_rxc)
			rxc_q <= data;
	end

	always_ff @(posedge i_clk)
	begin
		if (clr_all)
			rxm_q <= `RTB_REG_RESET;
		else if (wr_rxm)
			rxm_q <= data;
	end

	always_ff @(posedge i_clk)
	begin
		if (clr_all)
			txc_q <= `RTB_REG_RESET;
		else if (wr_txc)
			txc_q <= data;
	end

	always_ff @(posedge i_clk)
	begin
		if (clr_all)
			ofs_q <= `RTB_REG_RESET;
		else if (wr_ofs)
			ofs_q <= data;
	end

	// ==========================================================
	// Field decode
	// ==========================================================
	// amplifier power bit
	wire amp_pwr = gen_q[`RTB_GEN_AMP_BIT];

	// powersave when gen_q bits 5:0 are all clear, even if a channel select or amp invert leaves a block on
	wire pwr_save = ~(|gen_q[`RTB_GEN_PWR_HI:0]);

	wire drv_boost = rxc_q[`RTB_RXC_DRV_BIT];

	wire cor_en = rxc_q[`RTB_RXC_COR_BIT];

	// RF attenuation code, reserved codes passed unchanged
	wire [2:0] rf_step = rxc_q[`RTB_RXC_RF_HI:`RTB_RXC_RF_LO];

	wire [1:0] bb_step = rxc_q[`RTB_RXC_BB_HI:`RTB_RXC_BB_LO];

	// channel select, code 11 leaves both off
	wire rx_channel_sel_hi = rxm_q[`RTB_RXM_SEL_HI];
	wire rx_channel_sel_lo = rxm_q[`RTB_RXM_SEL_LO];
	wire i_chan_en         = ~rx_channel_sel_hi;
	wire q_chan_en         = ~rx_channel_sel_lo;

	wire i_amp_invert = rxm_q[`RTB_RXM_IINV_BIT];
	wire q_amp_invert = rxm_q[`RTB_RXM_QINV_BIT];
	wire i_amp_en     = amp_pwr ^ i_amp_invert;
	wire q_amp_en     = amp_pwr ^ q_amp_invert;

	wire [3:0] lo_trim_raw = rxm_q[`RTB_RXM_LO_HI:`RTB_RXM_LO_LO];
	wire [3:0] lo_trim     = cor_en ? lo_trim_raw : 4'h0;

	wire tx_src = txc_q[`RTB_TXC_SRC_BIT];

	wire [3:0] tx_trim = txc_q[`RTB_TXC_TRIM_HI:`RTB_TXC_TRIM_LO];

	wire [3:0] i_offset_trim = ofs_q[`RTB_OFS_I_HI:`RTB_OFS_I_LO];
	wire [3:0] q_offset_trim = ofs_q[`RTB_OFS_Q_HI:`RTB_OFS_Q_LO];

	logic       i_neg;
	logic [2:0] i_mag;
	logic       q_neg;
	logic [2:0] q_mag;

	rtb_ofs_dec u_i_ofs (
		.i_code (i_offset_trim),
		.o_neg  (i_neg),
		.o_mag  (i_mag)
	);

	rtb_ofs_dec u_q_ofs (
		.i_code (q_offset_trim),
		.o_neg  (q_neg),
		.o_mag  (q_mag)
	);

	// ==========================================================
	// Output registers
	// ==========================================================
	// One cycle behind the stored bytes, so analog controls see clean edges
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_powersave <= 1'b1;
			o_gen_ctrl  <= `RTB_REG_RESET;
		end
		else
		begin
			o_powersave <= pwr_save;
			o_gen_ctrl  <= gen_q;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_rx_output_drive_boost <= 1'b0;
			o_iq_balance_fix_enable <= 1'b0;
			o_rf_gain_step          <= 3'h0;
			o_bb_gain_step          <= 2'h0;
		end
		else
		begin
			o_rx_output_drive_boost <= drv_boost;
			o_iq_balance_fix_enable <= cor_en;
			o_rf_gain_step          <= rf_step;
			o_bb_gain_step          <= bb_step;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_rx_i_enable   <= 1'b1;
			o_rx_q_enable   <= 1'b1;
		end
		else
		begin
			o_rx_i_enable   <= i_chan_en;
			o_rx_q_enable   <= q_chan_en;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_i_amp_on      <= 1'b0;
			o_q_amp_on      <= 1'b0;
			o_lo_level_trim <= 4'h0;
		end
		else
		begin
			o_i_amp_on      <= i_amp_en;
			o_q_amp_on      <= q_amp_en;
			o_lo_level_trim <= lo_trim;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_tx_lo_source_sel <= 1'b0;
			o_tx_lo_path_trim  <= 4'h0;
		end
		else
		begin
			o_tx_lo_source_sel <= tx_src;
			o_tx_lo_path_trim  <= tx_trim;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_i_offset_neg <= 1'b0;
			o_i_offset_mag <= 3'h0;
		end
		else
		begin
			o_i_offset_neg <= i_neg;
			o_i_offset_mag <= i_mag;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_q_offset_neg <= 1'b0;
			o_q_offset_mag <= 3'h0;
		end
		else
		begin
			o_q_offset_neg <= q_neg;
			o_q_offset_mag <= q_mag;
		end
	end

endmodule : rtb_top

// [test/rtb_monitor.sv]
// Checker of serial port and decode relations at the bank's pins
`timescale 1ns/10ps
module rtb_monitor (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_sel_n,
	input  wire logic       i_sclk,
	input  wire logic       o_rdata,
	input  wire logic       o_rdata_oe,
	input  wire logic       o_powersave,
	input  wire logic [7:0] o_gen_ctrl,
	input  wire logic       o_iq_balance_fix_enable,
	input  wire logic [3:0] o_lo_level_trim,
	input  wire logic       o_i_offset_neg,
	input  wire logic [2:0] o_i_offset_mag,
	input  wire logic       o_q_offset_neg,
	input  wire logic [2:0] o_q_offset_mag
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// =====================================
	// Idle span counter, saturating
	logic [3:0] idle_q;
	logic [3:0] idle_d;
	assign idle_d = (!i_sel_n) ? 4'h0 : idle_q + {3'h0, idle_q != 4'hf};
	always_ff @(posedge i_clk)
		idle_q <= i_rst ? 4'h0 : idle_d;

	// =====================================
	// Properties
	property p_rst_state;
		$past(i_rst) |-> o_powersave && o_gen_ctrl == 8'h00 && !o_rdata_oe;
	endproperty
	property p_pwr;
		$stable(o_gen_ctrl)[*2] |-> o_powersave == (o_gen_ctrl[5:0] == 6'h00);
	endproperty
	property p_oe_drop;
		$rose(i_sel_n) |-> ##2 !o_rdata_oe;
	endproperty
	property p_oe_sel;
		$rose(o_rdata_oe) |-> !i_sel_n;
	endproperty
	property p_hold;
		$stable(i_sclk)[*4] ##0 (o_rdata_oe && $past(o_rdata_oe)) |-> $stable(o_rdata);
	endproperty
	property p_lo_gate;
		!o_iq_balance_fix_enable |-> o_lo_level_trim == 4'h0;
	endproperty
	property p_i_sign;
		o_i_offset_mag == 3'h0 |-> !o_i_offset_neg;
	endproperty
	property p_q_sign;
		o_q_offset_mag == 3'h0 |-> !o_q_offset_neg;
	endproperty
	property p_quiet;
		idle_q > 4'h8 |-> $stable(o_gen_ctrl) && $stable(o_lo_level_trim) && $stable(o_powersave);
	endproperty

	a_rst_state: assert property (p_rst_state)
		else $error("reset state wrong");
	a_pwr: assert property (p_pwr)
		else $error("powersave decode wrong");
	a_oe_drop: assert property (p_oe_drop)
		else $error("read drive left on");
	a_oe_sel: assert property (p_oe_sel)
		else $error("read drive outside frame");
	a_hold: assert property (p_hold)
		else $error("read bit moved without clock");
	a_lo_gate: assert property (p_lo_gate)
		else $error("lo trim not gated");
	a_i_sign: assert property (p_i_sign)
		else $error("i offset sign wrong");
	a_q_sign: assert property (p_q_sign)
		else $error("q offset sign wrong");
	a_quiet: assert property (p_quiet)
		else $error("settings moved while idle");

	c_read: cover property ($rose(o_rdata_oe));
	c_pwr_up: cover property ($fell(o_powersave));
	c_lo: cover property (o_lo_level_trim != 4'h0);
endmodule : rtb_monitor

// [test/rtb_host_model.sv]
// Serial host driving command frames into the control bank
`timescale 1ns/10ps
module rtb_host_model (
	input  wire logic i_clk,
	input  wire logic i_rdata,
	output logic      o_sel_n,
	output logic      o_sclk,
	output logic      o_cdata
);
	// Extra low-phase clocks, lets the bench run a slow host
	int slow = 0;

	initial
	begin
		o_sel_n = 1'b1;
		o_sclk  = 1'b0;
		o_cdata = 1'b0;
	end

	// =====================================
	// address then optional data
	task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic long,
		output logic [7:0] q);
		logic [15:0] w;
		w = {a, d};
		q = 8'h00;
		@(negedge i_clk);
		o_sel_n = 1'b0;
		for (int n = 0; n < (long ? 16 : 8); n++)
		begin
			@(negedge i_clk);
			o_sclk  = 1'b0;
			o_cdata = w[15 - n];
			repeat (4 + slow) @(negedge i_clk);
			if (n > 7)
				q = {q[6:0], i_rdata};
			o_sclk = 1'b1;
			repeat (3) @(negedge i_clk);
		end
		@(negedge i_clk);
		o_sclk = 1'b0;
		// Released data line must not keep its last value
		o_cdata = ~o_cdata;
		@(negedge i_clk);
		o_sel_n = 1'b1;
		repeat (3) @(negedge i_clk);
	endtask : xfer
endmodule : rtb_host_model

// [test/rtb_top_tb.sv]
// Self-checking bench for the receive/transmit control bank
`timescale 1ns/10ps
`include "rtb_cfg.svh"
module rtb_top_tb;
	logic        i_clk;
	logic        i_rst;
	wire         sel_n, sclk, cdata, rdata, rdata_oe;
	wire  [36:0] outs;
	logic [7:0]  gen, rxc, rxm, txc, ofs, q;
	int          bad_count, check_count;

	rtb_top u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_sel_n(sel_n), .i_sclk(sclk), .i_cdata(cdata),
		.o_rdata(rdata), .o_rdata_oe(rdata_oe), .o_powersave(outs[36]), .o_gen_ctrl(outs[35:28]),
		.o_rx_output_drive_boost(outs[27]), .o_iq_balance_fix_enable(outs[26]),
		.o_rf_gain_step(outs[25:23]), .o_bb_gain_step(outs[22:21]), .o_rx_i_enable(outs[20]),
		.o_rx_q_enable(outs[19]), .o_i_amp_on(outs[18]), .o_q_amp_on(outs[17]),
		.o_lo_level_trim(outs[16:13]), .o_tx_lo_source_sel(outs[12]),
		.o_tx_lo_path_trim(outs[11:8]), .o_i_offset_neg(outs[7]), .o_i_offset_mag(outs[6:4]),
		.o_q_offset_neg(outs[3]), .o_q_offset_mag(outs[2:0]));
	rtb_host_model u_host (.i_clk(i_clk), .i_rdata(rdata), .o_sel_n(sel_n), .o_sclk(sclk),
		.o_cdata(cdata));

	// =====================================
	// Expectations and comparisons
	function automatic logic [36:0] expect_outs();
		return {gen[5:0] == 6'h00, gen, rxc[7:6], rxc[4:2], rxc[1:0], ~rxm[7:6],
			gen[5] ^ rxm[5], gen[5] ^ rxm[4], rxc[6] ? rxm[3:0] : 4'h0, txc[7], txc[3:0],
			ofs[3] & |ofs[2:0], ofs[2:0], ofs[7] & |ofs[6:4], ofs[6:4]};
	endfunction : expect_outs

	task automatic chk_outs(input logic [36:0] e);
		check_count++;
		if (outs !== e)
		begin
			bad_count++;
			$display("mismatch outputs expected %h seen %h", e, outs);
		end
	endtask : chk_outs

	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		u_host.xfer(a, 8'h00, 1'b1, q);
		check_count++;
		if (q !== e)
		begin
			bad_count++;
			$display("mismatch readback %h expected %h seen %h", a, e, q);
		end
	endtask : chk_rd

	task automatic put_all();
		u_host.xfer(`RTB_ADDR_GEN_WR, gen, 1'b1, q);
		u_host.xfer(`RTB_ADDR_RXC_WR, rxc, 1'b1, q);
		u_host.xfer(`RTB_ADDR_RXM_WR, rxm, 1'b1, q);
		u_host.xfer(`RTB_ADDR_TXC_WR, txc, 1'b1, q);
		u_host.xfer(`RTB_ADDR_OFS_WR, ofs, 1'b1, q);
	endtask : put_all

	task automatic check_all();
		repeat (2) @(negedge i_clk);
		chk_outs(expect_outs());
		chk_rd(`RTB_ADDR_GEN_RD, gen);
		chk_rd(`RTB_ADDR_RXC_RD, rxc);
		chk_rd(`RTB_ADDR_RXM_RD, rxm);
		chk_rd(`RTB_ADDR_TXC_RD, txc);
		chk_rd(`RTB_ADDR_OFS_RD, ofs);
		// Read frames must leave every setting as it was
		chk_outs(expect_outs());
	endtask : check_all

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	// =====================================
	// Clock, watchdog and main sequence
	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	initial
	begin
		repeat (60000) @(posedge i_clk);
		bad_count++;
		give_verdict();
	end

	initial
	begin
		i_rst = 1'b1;
		bad_count = 0;
		check_count = 0;
		{gen, rxc, rxm, txc, ofs} = '0;
		q = 8'($urandom(22735));
		repeat (2) @(negedge i_clk);
		i_rst = 1'b0;
		check_all();
		for (int k = 0; k < 14; k++)
		begin
			{gen, rxc, rxm, txc, ofs} = 40'({$urandom, $urandom});
			u_host.slow = k % 2;
			rxc[5] = 1'b0;
			txc[6:4] = 3'h0;
			rxc[4:2] = 3'(k % 6);
			rxm[7:6] = 2'(k % 3);
			rxc[1:0] = 2'(k % 4);
			if (k < 8)
				{gen[5], rxm[5:4]} = 3'(k);
			if (k == 2)
				ofs = 8'h88;
			put_all();
			check_all();
		end
		// Refused and address-only frames change nothing
		u_host.xfer(`RTB_ADDR_RXC_RD, 8'h5a, 1'b1, q);
		u_host.xfer(8'h55, 8'h5a, 1'b1, q);
		u_host.xfer(`RTB_ADDR_TXC_WR, 8'h00, 1'b0, q);
		chk_rd(`RTB_ADDR_RXM_WR, 8'h00);
		// A write address takes the trailing byte of that frame as data
		rxm = 8'h00;
		check_all();
		u_host.xfer(`RTB_ADDR_RESET, 8'h00, 1'b0, q);
		{gen, rxc, rxm, txc, ofs} = '0;
		check_all();
		give_verdict();
	end
endmodule : rtb_top_tb

bind rtb_top rtb_monitor u_mon (.i_clk(i_clk), .i_rst(i_rst), .i_sel_n(i_sel_n),
	.i_sclk(i_sclk), .o_rdata(o_rdata), .o_rdata_oe(o_rdata_oe), .o_powersave(o_powersave),
	.o_gen_ctrl(o_gen_ctrl), .o_iq_balance_fix_enable(o_iq_balance_fix_enable),
	.o_lo_level_trim(o_lo_level_trim), .o_i_offset_neg(o_i_offset_neg),
	.o_i_offset_mag(o_i_offset_mag), .o_q_offset_neg(o_q_offset_neg),
	.o_q_offset_mag(o_q_offset_mag));
